//--- src/sic_pkg.sv
/*
 * Constants, field layout and selector codes of the status indicator control.
 * Assumes a 100 MHz mclk; long counts are overridable at the top module.
 */
package sic_pkg;

    // ****************************************************************
    // Clock and times
    // ****************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int CYC_PER_MS      = CLK_HZ / 1000;
    localparam int HOLD_30_MS      = 30;
    localparam int HOLD_60_MS      = 60;
    localparam int HOLD_100_MS     = 100;
    localparam int HOLD_30_CYC     = HOLD_30_MS * CYC_PER_MS;
    localparam int HOLD_60_CYC     = HOLD_60_MS * CYC_PER_MS;
    localparam int HOLD_100_CYC    = HOLD_100_MS * CYC_PER_MS;
    // Blink half periods, no rate given elsewhere
    localparam int BLINK_FAST_MS   = 50;
    localparam int BLINK_SLOW_MS   = 250;
    localparam int BLINK_FAST_CYC  = BLINK_FAST_MS * CYC_PER_MS;
    localparam int BLINK_SLOW_CYC  = BLINK_SLOW_MS * CYC_PER_MS;
    localparam int CNT_W           = 25;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int              ADDR_W        = 8;
    localparam logic [7:0]      CFG_ADDR      = 8'h14;
    localparam logic [15:0]     CFG_RST       = 16'h0422;
    localparam logic [15:0]     CFG_WMASK     = 16'hfffe;
    localparam int              SEL1_LSB      = 12;
    localparam int              SEL2_LSB      = 8;
    localparam int              SEL3_LSB      = 4;
    localparam int              DUR_LSB       = 2;
    localparam int              STRETCH_BIT   = 1;
    localparam logic [1:0]      RESP_OKAY     = 2'h0;
    localparam logic [1:0]      RESP_SLVERR   = 2'h2;

    // ****************************************************************
    // Selector and duration codes
    // ****************************************************************
    typedef enum logic [3:0] {
        SIC_SEL_SPEED    = 4'h0,
        SIC_SEL_TX       = 4'h1,
        SIC_SEL_RX       = 4'h2,
        SIC_SEL_COL      = 4'h3,
        SIC_SEL_LINK     = 4'h4,
        SIC_SEL_DUPLEX   = 4'h5,
        SIC_SEL_UNUSED_A = 4'h6,
        SIC_SEL_ACT      = 4'h7,
        SIC_SEL_ON       = 4'h8,
        SIC_SEL_OFF      = 4'h9,
        SIC_SEL_FAST     = 4'ha,
        SIC_SEL_SLOW     = 4'hb,
        SIC_SEL_LINK_RX  = 4'hc,
        SIC_SEL_LINK_ACT = 4'hd,
        SIC_SEL_DUP_COL  = 4'he,
        SIC_SEL_UNUSED_B = 4'hf
    } sic_sel_t;

    localparam logic [1:0] DUR_30  = 2'h0;
    localparam logic [1:0] DUR_60  = 2'h1;
    localparam logic [1:0] DUR_100 = 2'h2;

    // Event lines into the stretchers
    localparam int EV_TX  = 0;
    localparam int EV_RX  = 1;
    localparam int EV_COL = 2;
    localparam int EV_ACT = 3;
    localparam int EV_N   = 4;

endpackage

//--- src/sic_stretch.sv
/*
 * Pulse stretcher: output follows the event and holds for hold_cyc cycles
 * after it ends. Assumes hold_cyc is steady or changes only between events.
 */
module sic_stretch
    import sic_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         event_in,
    input  wire logic [W-1:0] hold_cyc,
    output logic              stretched
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } sic_str_state_t;

    sic_str_state_t st_reg;
    sic_str_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (event_in) begin
            st_next.cnt = hold_cyc;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign stretched = event_in | (st_reg.cnt != '0);

endmodule

//--- src/sic_blink.sv
/*
 * Free running square wave for the blink displays.
 * Assumes HALF_CYC fits in W bits and is at least one.
 */
module sic_blink
    import sic_pkg::*;
#(
    parameter int W        = CNT_W,
    parameter int HALF_CYC = BLINK_FAST_CYC
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      blink
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         lvl;
    } sic_blk_state_t;

    sic_blk_state_t st_reg;
    sic_blk_state_t st_next;

    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt >= W'(HALF_CYC - 1)) begin
            st_next.cnt = '0;
            st_next.lvl = ~st_reg.lvl;
        end else begin
            st_next.cnt = st_reg.cnt + W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign blink = st_reg.lvl;

endmodule

//--- src/sic_top.sv
/*
 * Status indicator control: one configuration register on AXI4-Lite picks
 * the source of three lamp outputs, with event stretching and blinking.
 * Assumes status inputs are synchronous to mclk; outputs drive lamp buffers.
 */
// Decided for this implementation: the AXI4-Lite register port.

// How it works
// RULE1: Three 4-bit selectors sit in config bits 15:12, 11:8 and 7:4.
// RULE2: Codes 0 to 5 show speed, transmit, receive, collision, link, duplex.
// RULE3: Speed, link, duplex are continuous; transmit, receive, collision are stretchable.
// RULE4: Code 7 shows receive or transmit activity as a stretchable event.
// RULE5: Codes 8 to 11 force on, off, fast blink, slow blink.
// RULE6: Software never programs codes 6 or 15; the lamp then stays off.
// RULE7: Code 12 is solid on with link up, blinks on receive events.
// RULE8: Code 13 shows link, and activity blinks whatever the link state.
// RULE9: Code 14 is solid on at full duplex, blinks on collisions.
// RULE10: Combined displays always stretch, regardless of the stretch enable bit.
// RULE11: Bits 3:2 choose hold time 30, 60 or 100 ms; 11 reserved.
// RULE12: Bit 1 enables stretching on all lamps, reset value one.
// RULE13: Reset selectors are speed, link, receive; duration field zero.
// RULE14: Software writes zero to bit 0 and ignores it on read.
// RULE15: Fast and slow blink half periods are parameters counted in mclk cycles.
module sic_top
    import sic_pkg::*;
#(
    parameter int HOLD_30   = HOLD_30_CYC,
    parameter int HOLD_60   = HOLD_60_CYC,
    parameter int HOLD_100  = HOLD_100_CYC,
    parameter int BLINK_FST = BLINK_FAST_CYC,
    parameter int BLINK_SLW = BLINK_SLOW_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              status_speed,
    input  wire logic              status_tx,
    input  wire logic              status_rx,
    input  wire logic              status_col,
    input  wire logic              status_link,
    input  wire logic              status_duplex,
    output logic                   first_indicator,
    output logic                   second_indicator,
    output logic                   third_indicator
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0]       cfg;
        logic              aw_got;
        logic              w_got;
        logic [ADDR_W-1:0] awaddr;
        logic [15:0]       wdata;
        logic [1:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [15:0]       rdata;
        logic [1:0]        rresp;
        logic [2:0]        ind;
    } sic_state_t;

    sic_state_t st_reg;
    sic_state_t st_next;

    logic [EV_N-1:0]  ev_raw;
    logic [EV_N-1:0]  ev_str;
    logic [CNT_W-1:0] hold_sel;
    logic             blink_fast;
    logic             blink_slow;
    logic             stretch_en;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [CNT_W-1:0] hold_of(input logic [1:0] dur);
        case (dur)
            DUR_30:  hold_of = CNT_W'(HOLD_30);   // see RULE11
            DUR_60:  hold_of = CNT_W'(HOLD_60);
            DUR_100: hold_of = CNT_W'(HOLD_100);
            default: hold_of = CNT_W'(HOLD_100);  // Reserved code, longest hold
        endcase
    endfunction

    function automatic logic lamp_of(input logic [3:0] sel);
        logic [EV_N-1:0] ev;
        lamp_of = 1'b0;
        ev = stretch_en ? ev_str : ev_raw;        // see RULE12
        case (sel)
            SIC_SEL_SPEED:    lamp_of = status_speed;   // see RULE2 RULE3
            SIC_SEL_TX:       lamp_of = ev[EV_TX];      // see RULE3
            SIC_SEL_RX:       lamp_of = ev[EV_RX];
            SIC_SEL_COL:      lamp_of = ev[EV_COL];
            SIC_SEL_LINK:     lamp_of = status_link;
            SIC_SEL_DUPLEX:   lamp_of = status_duplex;
            SIC_SEL_ACT:      lamp_of = ev[EV_ACT];     // see RULE4
            SIC_SEL_ON:       lamp_of = 1'b1;           // see RULE5
            SIC_SEL_OFF:      lamp_of = 1'b0;
            SIC_SEL_FAST:     lamp_of = blink_fast;     // see RULE15
            SIC_SEL_SLOW:     lamp_of = blink_slow;
            // Combined: primary level, inverted by blink while the event lasts
            SIC_SEL_LINK_RX:  lamp_of = status_link ^ (ev_str[EV_RX] & blink_fast);    // see RULE7 RULE10
            SIC_SEL_LINK_ACT: lamp_of = status_link ^ (ev_str[EV_ACT] & blink_fast);   // see RULE8 RULE10
            SIC_SEL_DUP_COL:  lamp_of = status_duplex ^ (ev_str[EV_COL] & blink_fast); // see RULE9 RULE10
            default:          lamp_of = 1'b0;           // see RULE6
        endcase
    endfunction

    // ****************************************************************
    // Event stretchers and blink sources
    // ****************************************************************
    assign ev_raw[EV_TX]  = status_tx;
    assign ev_raw[EV_RX]  = status_rx;
    assign ev_raw[EV_COL] = status_col;
    assign ev_raw[EV_ACT] = status_tx | status_rx;
    assign hold_sel       = hold_of(st_reg.cfg[DUR_LSB +: 2]);
    assign stretch_en     = st_reg.cfg[STRETCH_BIT];

    for (genvar i = 0; i < EV_N; i++) begin : g_str
        sic_stretch #(
            .W         (CNT_W)
        ) u_str (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .event_in  (ev_raw[i]),
            .hold_cyc  (hold_sel),
            .stretched (ev_str[i])
        );
    end

    sic_blink #(
        .W        (CNT_W),
        .HALF_CYC (BLINK_FST)
    ) u_fast (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .blink    (blink_fast)
    );

    sic_blink #(
        .W        (CNT_W),
        .HALF_CYC (BLINK_SLW)
    ) u_slow (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .blink    (blink_slow)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        // Write address and data are taken in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_got  = 1'b1;
            st_next.awaddr  = s_axi_awaddr;
            st_next.awready = 1'b0;
        end
        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_got  = 1'b1;
            st_next.wdata  = s_axi_wdata[15:0];
            st_next.wstrb  = s_axi_wstrb[1:0];
            st_next.wready = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = RESP_SLVERR;
            if (st_reg.awaddr[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]) begin
                st_next.bresp = RESP_OKAY;
                for (int b = 0; b < 2; b++) begin
                    if (st_reg.wstrb[b]) begin
                        st_next.cfg[b*8 +: 8] = st_reg.wdata[b*8 +: 8];
                    end
                end
                st_next.cfg = st_next.cfg & CFG_WMASK;  // see RULE14
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid  = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
        end
        if (s_axi_arvalid && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid  = 1'b1;
            st_next.rdata   = '0;
            st_next.rresp   = RESP_SLVERR;
            if (s_axi_araddr[ADDR_W-1:2] == CFG_ADDR[ADDR_W-1:2]) begin
                st_next.rdata = st_reg.cfg;
                st_next.rresp = RESP_OKAY;
            end
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end
        st_next.ind[0] = lamp_of(st_reg.cfg[SEL1_LSB +: 4]);  // see RULE1
        st_next.ind[1] = lamp_of(st_reg.cfg[SEL2_LSB +: 4]);
        st_next.ind[2] = lamp_of(st_reg.cfg[SEL3_LSB +: 4]);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.cfg     <= CFG_RST;  // see RULE13
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready    = st_reg.awready;
    assign s_axi_wready     = st_reg.wready;
    assign s_axi_bvalid     = st_reg.bvalid;
    assign s_axi_bresp      = st_reg.bresp;
    assign s_axi_arready    = st_reg.arready;
    assign s_axi_rvalid     = st_reg.rvalid;
    assign s_axi_rresp      = st_reg.rresp;
    assign s_axi_rdata      = {16'h0000, st_reg.rdata};
    assign first_indicator  = st_reg.ind[0];
    assign second_indicator = st_reg.ind[1];
    assign third_indicator  = st_reg.ind[2];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_reset_cfg;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rst_n) |-> st_reg.cfg == CFG_RST;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("config reset value wrong"); // see RULE13

    property p_link_first;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.cfg[SEL1_LSB +: 4] == SIC_SEL_LINK |=> first_indicator == $past(status_link);
    endproperty
    a_link_first: assert property (p_link_first) else $error("link display wrong"); // see RULE2

    property p_force_on;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.cfg[SEL2_LSB +: 4] == SIC_SEL_ON [*2] |-> second_indicator;
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced on lamp dark"); // see RULE5

    property p_force_off;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.cfg[SEL3_LSB +: 4] == SIC_SEL_OFF |=> !third_indicator;
    endproperty
    a_force_off: assert property (p_force_off) else $error("forced off lamp lit"); // see RULE5

    property p_tx_stretch;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL3_LSB +: 4] == SIC_SEL_TX && stretch_en && $fell(status_tx))
            |=> third_indicator;
    endproperty
    a_tx_stretch: assert property (p_tx_stretch) else $error("tx event not held"); // see RULE3

    property p_tx_raw;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL1_LSB +: 4] == SIC_SEL_TX && !stretch_en)
            |=> first_indicator == $past(status_tx);
    endproperty
    a_tx_raw: assert property (p_tx_raw) else $error("tx shown stretched while disabled"); // see RULE12

    property p_act_raw;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL2_LSB +: 4] == SIC_SEL_ACT && !stretch_en)
            |=> second_indicator == ($past(status_tx) | $past(status_rx));
    endproperty
    a_act_raw: assert property (p_act_raw) else $error("activity display wrong"); // see RULE4

    property p_link_rx_solid;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL1_LSB +: 4] == SIC_SEL_LINK_RX && status_link && !ev_str[EV_RX])
            |=> first_indicator;
    endproperty
    a_link_rx_solid: assert property (p_link_rx_solid) else $error("link lamp not solid"); // see RULE7

    property p_act_blinks_down;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL2_LSB +: 4] == SIC_SEL_LINK_ACT && !status_link && !stretch_en
            && ev_str[EV_ACT] && blink_fast) |=> second_indicator;
    endproperty
    a_act_blinks_down: assert property (p_act_blinks_down) else $error("activity blink lost"); // see RULE8 RULE10

    property p_dup_col;
        @(posedge mclk) disable iff (!rst_n)
        (st_reg.cfg[SEL3_LSB +: 4] == SIC_SEL_DUP_COL && !status_duplex && !ev_str[EV_COL])
            |=> !third_indicator;
    endproperty
    a_dup_col: assert property (p_dup_col) else $error("half duplex lamp lit"); // see RULE9

    property p_hold_sel;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.cfg[DUR_LSB +: 2] == DUR_60 |-> hold_sel == CNT_W'(HOLD_60);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("hold time select wrong"); // see RULE11

    property p_fast_blink;
        @(posedge mclk) disable iff (!rst_n)
        st_reg.cfg[SEL1_LSB +: 4] == SIC_SEL_FAST |=> first_indicator == $past(blink_fast);
    endproperty
    a_fast_blink: assert property (p_fast_blink) else $error("fast blink not shown"); // see RULE15

    property p_bvalid_holds;
        @(posedge mclk) disable iff (!rst_n)
        s_axi_bvalid |=> (s_axi_bvalid && $stable(s_axi_bresp)) || $past(s_axi_bready);
    endproperty
    a_bvalid_holds: assert property (p_bvalid_holds) else $error("write response dropped");

endmodule

//--- tb/sic_lamp_model.sv
/*
 * Lamp model at the three indicator outputs: counts changes of each lamp.
 * Assumes lamps are sampled on mclk; clr zeroes all counts at an edge.
 */
module sic_lamp_model (
    input  wire logic        mclk,
    input  wire logic        clr,
    input  wire logic [2:0]  lamps,
    output logic      [23:0] toggles
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] last_lit = 3'h0;

    // Counts saturate nowhere; windows are kept short by the bench
    always @(posedge mclk) begin
        last_lit <= lamps;
        for (int i = 0; i < 3; i++) begin
            if (clr) begin
                toggles[8*i +: 8] <= 8'h0;
            end else if (lamps[i] !== last_lit[i]) begin
                toggles[8*i +: 8] <= toggles[8*i +: 8] + 8'h1;
            end
        end
    end
endmodule

//--- tb/status_indicator_control_bench.sv
/*
 * Bench of the status indicator control: AXI4-Lite master, random status
 * traffic and lamp checks. Assumes short hold and blink parameters.
 */
module status_indicator_control_bench
    import sic_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam logic [35:0] CODES = 36'h012345789;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        first_indicator, second_indicator, third_indicator;
    logic [5:0]  st = 6'h0;
    logic [5:0]  st_prev;
    logic        clr = 1'b0;
    logic [23:0] toggles;
    logic [2:0]  lamps;
    logic [31:0] seed = 32'h642a2bff;
    logic [33:0] exp_q[$];
    int          miscompares = 0;
    int          compares = 0;
    int          n;

    always #5 mclk = ~mclk;
    assign lamps = {first_indicator, second_indicator, third_indicator};

    sic_top #(.HOLD_30(30), .HOLD_60(60), .HOLD_100(100), .BLINK_FST(8), .BLINK_SLW(32))
        sic_top_inst (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .status_speed(st[0]), .status_tx(st[1]), .status_rx(st[2]),
        .status_col(st[3]), .status_link(st[4]), .status_duplex(st[5]),
        .first_indicator, .second_indicator, .third_indicator);

    sic_lamp_model sic_lamp_model_inst (.mclk, .clr, .lamps, .toggles);

    // ****************************************************************
    // Helpers and bus tasks
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [3:0] code(input int i);
        return CODES[4 * (8 - i) +: 4];
    endfunction

    function automatic logic src(input logic [3:0] c, input logic [5:0] s);
        case (c)
            4'h0: return s[0];
            4'h1: return s[1];
            4'h2: return s[2];
            4'h3: return s[3];
            4'h4: return s[4];
            4'h5: return s[5];
            4'h7: return s[1] | s[2];
            4'h8: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bound(input int i);
        if (i > 100) begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        int i;
        i = 0;
        exp_q.push_back({r, 32'h0});
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            i++;
            bound(i);
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        i = 0;
        exp_q.push_back({r, d});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            i++;
            bound(i);
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    // Lamp follows the source sampled one edge earlier
    task automatic run(input logic [15:0] cfg);
        logic [2:0] e;
        wr(CFG_ADDR, cfg, 4'h3, RESP_OKAY);
        rd(CFG_ADDR, {16'h0, cfg}, RESP_OKAY);
        st_prev = st;
        repeat (24) begin
            @(posedge mclk);
            e = {src(cfg[15:12], st_prev), src(cfg[11:8], st_prev), src(cfg[7:4], st_prev)};
            chk({31'h0, lamps}, {31'h0, e});
            st_prev = st;
            seed = lfsr(seed);
            st <= seed[5:0];
        end
    endtask

    always @(posedge mclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
        if (s_axi_rvalid && s_axi_rready) begin
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
    end

    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        st <= 6'h01;
        repeat (3) @(posedge mclk);
        chk({31'h0, lamps}, {31'h0, 3'b100});
        rd(CFG_ADDR, 32'h0422, RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h18, 16'h0000, 4'h3, RESP_SLVERR);
        wr(CFG_ADDR, 16'h0090, 4'h1, RESP_OKAY);
        rd(CFG_ADDR, 32'h0490, RESP_OKAY);
        for (int i = 0; i < 9; i++) begin
            run({code(i), code((i + 3) % 9), code((i + 6) % 9), 4'h0});
        end
        st <= 6'h0;
        for (int k = 0; k < 4; k++) begin
            wr(CFG_ADDR, {12'h441, k[1:0], 2'b10}, 4'h3, RESP_OKAY);
            @(posedge mclk);
            st <= 6'h02;
            @(posedge mclk);
            st <= 6'h00;
            n = 0;
            repeat (150) begin
                @(posedge mclk);
                n += (third_indicator === 1'b1);
            end
            // Reserved duration code holds as long as the longest one
            n -= (k == 0 ? 30 : k == 1 ? 60 : 100);
            chk({33'h0, n >= 0 && n <= 2}, 34'h1);
        end
        // Stretch disabled: only the combined displays may hold their events
        wr(CFG_ADDR, 16'hcde0, 4'h3, RESP_OKAY);
        for (int p = 1; p >= 0; p--) begin
            st <= {p[0], p[0], 4'h0};
            repeat (4) @(posedge mclk);
            chk({31'h0, lamps}, {31'h0, {3{p[0]}}});
            clr <= 1'b1;
            st[3:1] <= 3'h7;
            @(posedge mclk);
            clr <= 1'b0;
            st[3:1] <= 3'h0;
            repeat (40) @(posedge mclk);
            #1;
            chk({31'h0, toggles[23:16] > 2, toggles[15:8] > 2, toggles[7:0] > 2}, 34'h7);
            repeat (40) @(posedge mclk);
            chk({31'h0, lamps}, {31'h0, {3{p[0]}}});
        end
        wr(CFG_ADDR, 16'hab90, 4'h3, RESP_OKAY);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (64) @(posedge mclk);
        #1;
        chk({10'h0, toggles}, {10'h0, 8'd8, 8'd2, 8'd0});
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(CFG_ADDR, 32'h0422, RESP_OKAY);
        tally_and_finish();
    end
endmodule
